// ===== src/gpr_pkg.sv
// Constants, field layouts and types for the gigabit status and indirect register slice.
package gpr_pkg;

    // ========================================================================
    // Management frame layout
    // ========================================================================
    localparam logic [5:0]  PREAMBLE_LEN     = 6'h20;
    localparam logic [5:0]  HEADER_LAST_BIT  = 6'h0C;
    localparam logic [5:0]  DATA_LAST_BIT    = 6'h0F;
    localparam logic [1:0]  OP_READ          = 2'h2;
    localparam logic [1:0]  OP_WRITE         = 2'h1;
    // Arbitrary default management address of this port.
    localparam logic [4:0]  PHY_ADDR_DEFAULT = 5'h01;

    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam logic [4:0]  REG_GIGABIT_CONFIG          = 5'h09;
    localparam logic [4:0]  REG_GIGABIT_LINK_STATUS     = 5'h0A;
    localparam logic [4:0]  REG_INDIRECT_ACCESS_CONTROL = 5'h0D;
    localparam logic [4:0]  REG_INDIRECT_ADDRESS_DATA   = 5'h0E;
    localparam logic [4:0]  REG_GIGABIT_CAPABILITY      = 5'h0F;

    // ========================================================================
    // Field positions and values
    // ========================================================================
    localparam int          CFG_MANUAL_EN_BIT  = 12;
    localparam int          CFG_MANUAL_VAL_BIT = 11;
    localparam int          LS_FAULT_BIT       = 15;
    localparam int          LS_STATUS_LSB      = 10;
    localparam int          CTRL_FUNC_LSB      = 14;
    localparam logic [4:0]  DEVICE_ADDRESS_EXT = 5'h1F;
    localparam logic [15:0] CAPABILITY_VALUE   = 16'h3000;
    localparam logic [7:0]  IDLE_COUNT_MAX     = 8'hFF;
    localparam logic [15:0] POINTER_RESET      = 16'h0000;
    localparam logic [10:0] EXT_WINDOW_BASE    = 11'h001;
    localparam int          EXT_DEPTH          = 32;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        FN_ADDRESS     = 2'b00,
        FN_DATA        = 2'b01,
        FN_DATA_INC_RW = 2'b10,
        FN_DATA_INC_WR = 2'b11
    } gpr_func_t;

    typedef enum logic [1:0] {
        ST_PREAMBLE = 2'b00,
        ST_HEADER   = 2'b01,
        ST_TURN     = 2'b10,
        ST_DATA     = 2'b11
    } gpr_state_t;

endpackage : gpr_pkg

// ===== src/gpr_phy_regs.sv
// Management frame slave holding the gigabit status, indirect window and capability registers.
// How it works
// R1 - Fault flag latches on manual master/slave fault, clears when status is read.
// R2 - Resolution bit reads 1 for master, 0 for slave.
// R3 - Local receiver OK bit, read only, resets to 0.
// R4 - Remote receiver OK bit, read only, resets to 0.
// R5 - Partner gigabit full and half duplex ability bits, read only, reset 0.
// R6 - Reserved bits ignore writes and read as zero.
// R7 - Eight-bit idle error counter in status low byte, cleared on read.
// R8 - Idle error counter saturates at 255 until read.
// R9 - Extended registers above 0x1F reached only through control and address/data.
// R10 - Function 00: address/data write loads the extended pointer.
// R11 - Function 01: access selected register, pointer unchanged.
// R12 - Function 10: access selected register, then pointer increments.
// R13 - Function 11: pointer increments after writes only.
// R14 - Indirect accesses act only when device address field is 11111.
// R15 - Host programs 0x1F into device address field before indirect use.
// R16 - Host loads the pointer with function 00 before data access.
// R17 - Address/data reads pointer under function 00, else selected register data.
// R18 - Capability reads fixed: fiber duplex 0, twisted-pair duplex 1.
// R19 - Config bits enable manual master/slave and choose master; conflicts raise fault.
// R20 - All accesses travel in clause 22 management frames on data and clock.
`timescale 1ns/1ps

module gpr_phy_regs
    import gpr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic mdc,
    input  wire logic mdio_in,
    output logic      mdio_out,
    output logic      mdio_oe,
    input  wire logic ms_fault_event,
    input  wire logic ms_resolved_master,
    input  wire logic local_rx_ok,
    input  wire logic remote_rx_ok,
    input  wire logic lp_1000_fd,
    input  wire logic lp_1000_hd,
    input  wire logic idle_error,
    output logic      manual_ms_enable,
    output logic      manual_ms_value
);

    // ========================================================================
    // Frame receiver
    // ========================================================================
    gpr_state_t  state_reg;
    logic        mdc_q_reg;
    logic [5:0]  cnt_reg;
    logic [11:0] hdr_reg;
    logic [15:0] data_reg;
    logic        is_read_reg;
    logic        hit_reg;
    logic [4:0]  addr_reg;
    logic        mdio_out_reg;
    logic        mdio_oe_reg;
    logic [15:0] read_value;

    wire         mdc_rise   = mdc & ~mdc_q_reg;
    wire  [12:0] hdr_full   = {hdr_reg, mdio_in};
    wire         hdr_valid  = hdr_full[12] &
                              (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
    wire         rd_fire    = mdc_rise & (state_reg == ST_TURN) & (cnt_reg == 6'h00)
                              & is_read_reg & hit_reg;
    wire         wr_fire    = mdc_rise & (state_reg == ST_DATA) & (cnt_reg == DATA_LAST_BIT)
                              & ~is_read_reg & hit_reg;
    wire  [15:0] wr_data    = {data_reg[14:0], mdio_in};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mdc_q_reg <= 1'b0;
        end else begin
            mdc_q_reg <= mdc;
        end
    end

    // The port answers on the mdc rising edge, and the host samples the settled level three clock cycles later, before the next mdc edge.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= ST_PREAMBLE;
            cnt_reg      <= 6'h00;
            hdr_reg      <= 12'h000;
            data_reg     <= 16'h0000;
            is_read_reg  <= 1'b0;
            hit_reg      <= 1'b0;
            addr_reg     <= 5'h00;
            mdio_out_reg <= 1'b0;
            mdio_oe_reg  <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_reg)
                ST_PREAMBLE: begin
                    if (mdio_in) begin
                        cnt_reg <= (cnt_reg == PREAMBLE_LEN) ? cnt_reg : cnt_reg + 6'h01;
                    end else begin
                        state_reg <= (cnt_reg == PREAMBLE_LEN) ? ST_HEADER : ST_PREAMBLE; // R20
                        cnt_reg   <= 6'h00;
                    end
                end
                ST_HEADER: begin
                    hdr_reg <= hdr_full[11:0];
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == HEADER_LAST_BIT) begin
                        state_reg   <= hdr_valid ? ST_TURN : ST_PREAMBLE;
                        cnt_reg     <= 6'h00;
                        is_read_reg <= (hdr_full[11:10] == OP_READ);
                        hit_reg     <= hdr_valid & (hdr_full[9:5] == PHY_ADDR); // R20
                        addr_reg    <= hdr_full[4:0];
                    end
                end
                ST_TURN: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'h00) begin
                        mdio_oe_reg  <= rd_fire;
                        mdio_out_reg <= 1'b0;
                        data_reg     <= read_value;
                    end else begin
                        state_reg    <= ST_DATA;
                        cnt_reg      <= 6'h00;
                        mdio_out_reg <= data_reg[15];
                        data_reg     <= {data_reg[14:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (is_read_reg) begin
                        mdio_out_reg <= data_reg[15];
                        data_reg     <= {data_reg[14:0], 1'b0};
                    end else begin
                        data_reg <= wr_data;
                    end
                    if (cnt_reg == DATA_LAST_BIT) begin
                        state_reg   <= ST_PREAMBLE;
                        cnt_reg     <= 6'h00;
                        mdio_oe_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign mdio_out = mdio_out_reg;
    assign mdio_oe  = mdio_oe_reg;

    // ========================================================================
    // Register decode
    // ========================================================================
    logic [1:0]  cfg_reg;
    gpr_func_t   func_reg;
    logic [4:0]  device_address_field_reg;
    logic [15:0] pointer_reg;
    logic        fault_reg;
    logic [4:0]  status_reg;
    logic [7:0]  idle_cnt_reg;
    logic [15:0] ext_mem [EXT_DEPTH];

    wire sel_cfg    = (addr_reg == REG_GIGABIT_CONFIG);
    wire sel_status = (addr_reg == REG_GIGABIT_LINK_STATUS);
    wire sel_ctrl   = (addr_reg == REG_INDIRECT_ACCESS_CONTROL);
    wire sel_window = (addr_reg == REG_INDIRECT_ADDRESS_DATA);
    wire sel_cap    = (addr_reg == REG_GIGABIT_CAPABILITY);
    wire device_address_field_ok   = (device_address_field_reg == DEVICE_ADDRESS_EXT);                           // R14
    wire win_rd     = rd_fire & sel_window & device_address_field_ok;
    wire win_wr     = wr_fire & sel_window & device_address_field_ok;
    wire is_addr_fn = (func_reg == FN_ADDRESS);
    // Only the first window above the base registers is backed by storage; the rest read zero.
    wire ext_hit    = (pointer_reg[15:5] == EXT_WINDOW_BASE);                     // R9
    wire [4:0] ext_idx = pointer_reg[4:0];
    wire [15:0] ext_data = ext_hit ? ext_mem[ext_idx] : 16'h0000;
    wire ptr_load   = win_wr & is_addr_fn;                                         // R10
    wire ptr_inc    = (~is_addr_fn) & ((win_rd & (func_reg == FN_DATA_INC_RW))     // R12
                      | (win_wr & (func_reg == FN_DATA_INC_RW || func_reg == FN_DATA_INC_WR))); // R13
    wire status_rd  = rd_fire & sel_status;
    wire fault_set  = ms_fault_event & cfg_reg[1];                                 // R19
    wire [15:0] status_word = {fault_reg, status_reg, 1'b0, 1'b0, idle_cnt_reg};  // R6
    wire [15:0] ctrl_word   = {func_reg, 9'h000, device_address_field_reg};                       // R6
    wire [15:0] cfg_word    = {3'h0, cfg_reg, 11'h000};
    wire [15:0] window_word = ~device_address_field_ok ? 16'h0000 : is_addr_fn ? pointer_reg : ext_data; // R17

    assign read_value = sel_status ? status_word :
                        sel_ctrl   ? ctrl_word   :
                        sel_window ? window_word :
                        sel_cap    ? CAPABILITY_VALUE :                            // R18
                        sel_cfg    ? cfg_word    : 16'h0000;

    assign manual_ms_enable = cfg_reg[1];
    assign manual_ms_value  = cfg_reg[0];

    // ========================================================================
    // Register state
    // ========================================================================
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_reg   <= 2'h0;
            func_reg  <= FN_ADDRESS;
            device_address_field_reg <= 5'h00;
        end else begin
            if (wr_fire & sel_cfg) begin
                cfg_reg <= {wr_data[CFG_MANUAL_EN_BIT], wr_data[CFG_MANUAL_VAL_BIT]}; // R19
            end
            if (wr_fire & sel_ctrl) begin
                func_reg  <= gpr_func_t'(wr_data[CTRL_FUNC_LSB +: 2]);
                device_address_field_reg <= wr_data[4:0];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pointer_reg <= POINTER_RESET;
        end else if (ptr_load) begin
            pointer_reg <= wr_data;                                                // R10
        end else if (ptr_inc) begin
            pointer_reg <= pointer_reg + 16'h0001;                                 // R12
        end
    end

    always_ff @(posedge clock) begin
        if (win_wr & ~is_addr_fn & ext_hit) begin
            ext_mem[ext_idx] <= wr_data;                                           // R11
        end
    end

    // A fault or idle error in the same cycle as the clearing read survives the clear.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fault_reg    <= 1'b0;
            status_reg   <= 5'h00;
            idle_cnt_reg <= 8'h00;
        end else begin
            fault_reg  <= fault_set | (fault_reg & ~status_rd);                    // R1
            status_reg <= {ms_resolved_master, local_rx_ok, remote_rx_ok,          // R2 R3 R4
                           lp_1000_fd, lp_1000_hd};                                // R5
            if (idle_error) begin
                idle_cnt_reg <= status_rd ? 8'h01 :
                                (idle_cnt_reg == IDLE_COUNT_MAX) ? idle_cnt_reg :  // R8
                                idle_cnt_reg + 8'h01;
            end else if (status_rd) begin
                idle_cnt_reg <= 8'h00;                                             // R7
            end
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    property p_fault_set;
        @(posedge clock) disable iff (!resetn)
        fault_set |=> fault_reg ##1 (fault_reg || $past(status_rd));
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not latched"); // R1

    property p_fault_clear;
        @(posedge clock) disable iff (!resetn)
        (status_rd && !fault_set) |=> !fault_reg;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared"); // R1

    property p_idle_sat;
        @(posedge clock) disable iff (!resetn)
        (idle_cnt_reg == IDLE_COUNT_MAX && !status_rd) |=> (idle_cnt_reg == IDLE_COUNT_MAX);
    endproperty
    a_idle_sat: assert property (p_idle_sat) else $error("idle counter wrapped"); // R8

    property p_idle_clear;
        @(posedge clock) disable iff (!resetn)
        (status_rd && !idle_error) |=> (idle_cnt_reg == 8'h00);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle counter kept"); // R7

    property p_ptr_load;
        @(posedge clock) disable iff (!resetn)
        ptr_load |=> (pointer_reg == $past(wr_data));
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R10

    property p_ptr_hold;
        @(posedge clock) disable iff (!resetn)
        ((win_rd || win_wr) && func_reg == FN_DATA) |=> $stable(pointer_reg);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved"); // R11

    property p_ptr_inc;
        @(posedge clock) disable iff (!resetn)
        ((win_rd || win_wr) && func_reg == FN_DATA_INC_RW)
            |=> (pointer_reg == $past(pointer_reg) + 16'h0001);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented"); // R12

    property p_ptr_rd_wo;
        @(posedge clock) disable iff (!resetn)
        (win_rd && func_reg == FN_DATA_INC_WR) |=> $stable(pointer_reg);
    endproperty
    a_ptr_rd_wo: assert property (p_ptr_rd_wo) else $error("pointer moved on read"); // R13

    property p_device_address_field;
        @(posedge clock) disable iff (!resetn)
        ((rd_fire || wr_fire) && sel_window && !device_address_field_ok) |=> $stable(pointer_reg);
    endproperty
    a_device_address_field: assert property (p_device_address_field) else $error("foreign device address acted"); // R14

    property p_cap;
        @(posedge clock) disable iff (!resetn)
        (rd_fire && sel_cap) |=> (data_reg == CAPABILITY_VALUE);
    endproperty
    a_cap: assert property (p_cap) else $error("capability word wrong"); // R18

    property p_turn_drive;
        @(posedge clock) disable iff (!resetn)
        rd_fire |=> (mdio_oe && !mdio_out);
    endproperty
    a_turn_drive: assert property (p_turn_drive) else $error("turnaround not driven"); // R20

endmodule : gpr_phy_regs

// ===== tb/gpr_mgmt_host.sv
// Management host model that sends clause 22 frames on the management clock and data line.
`timescale 1ns/1ps

module gpr_mgmt_host
    import gpr_pkg::*;
(
    input  wire logic clock,
    input  wire logic mdio_wire,
    output logic      mdc,
    output logic      host_drive,
    output logic      host_oe
);
    // ========================================================================
    // Frame engine
    // ========================================================================
    // The clock only runs inside frames and rests low between them.
    initial begin
        mdc = 1'b0;
        host_drive = 1'b1;
        host_oe = 1'b0;
    end

    function automatic logic [15:0] ctl(input gpr_func_t f, input logic [4:0] da);
        return {f, 9'h000, da};
    endfunction : ctl

    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'b01, op, PHY_ADDR_DEFAULT, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clock) #1;
            mdc = 1'b0;
            // On a read the line is let go for turnaround and data, so the pull-up shows.
            host_oe = (op == OP_WRITE) || (i > 17);
            host_drive = bits[i];
            repeat (3) @(posedge clock);
            #1 mdc = 1'b1;
            repeat (3) @(posedge clock);
            #1;
            if (i >= 1 && i <= 16) begin
                rd[i-1] = mdio_wire;
            end
        end
        @(posedge clock) #1;
        mdc = 1'b0;
        host_oe = 1'b0;
        repeat (3) @(posedge clock);
    endtask : frame

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] unused;
        frame(OP_WRITE, ra, wd, unused);
    endtask : wr

    task automatic rd(input logic [4:0] ra, output logic [15:0] v);
        frame(OP_READ, ra, 16'h0000, v);
    endtask : rd

    task automatic ext_setup(input gpr_func_t f, input logic [15:0] ptr);
        wr(REG_INDIRECT_ACCESS_CONTROL, ctl(FN_ADDRESS, DEVICE_ADDRESS_EXT));
        wr(REG_INDIRECT_ADDRESS_DATA, ptr);
        wr(REG_INDIRECT_ACCESS_CONTROL, ctl(f, DEVICE_ADDRESS_EXT));
    endtask : ext_setup
endmodule : gpr_mgmt_host

// ===== tb/tb_top.sv
// Self-checking bench for the gigabit status and indirect register slice.
`timescale 1ns/1ps

module tb_top
    import gpr_pkg::*;
;
    logic        clock;
    logic        resetn;
    logic        mdc;
    logic        mdio_w;
    logic        mdio_out;
    logic        mdio_oe;
    logic        h_d;
    logic        h_oe;
    logic        ms_fault_event;
    logic [4:0]  st;
    logic        idle_error;
    logic        manual_ms_enable;
    logic        manual_ms_value;
    integer      mismatches;
    integer      samples_checked;
    integer      cycles;
    logic [15:0] v;

    assign mdio_w = mdio_oe ? mdio_out : (h_oe ? h_d : 1'b1);

    gpr_mgmt_host host (.clock(clock), .mdio_wire(mdio_w), .mdc(mdc),
                        .host_drive(h_d), .host_oe(h_oe));

    gpr_phy_regs dut (.clock(clock), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_w),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .ms_fault_event(ms_fault_event),
        .ms_resolved_master(st[4]), .local_rx_ok(st[3]), .remote_rx_ok(st[2]),
        .lp_1000_fd(st[1]), .lp_1000_hd(st[0]), .idle_error(idle_error),
        .manual_ms_enable(manual_ms_enable), .manual_ms_value(manual_ms_value));

    // ========================================================================
    // Checking and closing
    // ========================================================================
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rc(input logic [4:0] ra, input logic [15:0] exp);
        host.rd(ra, v);
        chk($sformatf("reg_%h", ra), v, exp);
    endtask : rc

    task automatic end_sim();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // The selector picks the input to raise: 0 for the fault event, 1 for idle errors.
    task automatic pulse(input bit which, input int n);
        @(posedge clock) #1;
        if (which) begin
            idle_error = 1'b1;
        end else begin
            ms_fault_event = 1'b1;
        end
        repeat (n) @(posedge clock);
        #1;
        idle_error = 1'b0;
        ms_fault_event = 1'b0;
        repeat (2) @(posedge clock);
    endtask : pulse

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_reset_values();
        rc(REG_GIGABIT_LINK_STATUS, 16'h0000);
        rc(REG_INDIRECT_ACCESS_CONTROL, 16'h0000);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'h0000);
        rc(REG_GIGABIT_CAPABILITY, CAPABILITY_VALUE);
        rc(5'h10, 16'h0000);
    endtask : t_reset_values

    task automatic t_status();
        logic [4:0] tbl [3];
        tbl = '{5'b10110, 5'b01001, 5'b11111};
        foreach (tbl[k]) begin
            @(posedge clock) #1 st = tbl[k];
            repeat (2) @(posedge clock);
            rc(REG_GIGABIT_LINK_STATUS, {1'b0, tbl[k], 10'h000});
        end
        @(posedge clock) #1 st = 5'b00000;
    endtask : t_status

    task automatic t_fault();
        host.wr(REG_GIGABIT_CONFIG, 16'hFFFF);
        chk("ms_en", {15'h0, manual_ms_enable}, 16'h0001);
        chk("ms_val", {15'h0, manual_ms_value}, 16'h0001);
        rc(REG_GIGABIT_CONFIG, 16'h1800);
        pulse(1'b0, 1);
        rc(REG_GIGABIT_LINK_STATUS, 16'h8000);
        rc(REG_GIGABIT_LINK_STATUS, 16'h0000);
        host.wr(REG_GIGABIT_CONFIG, 16'h0000);
        chk("ms_en", {15'h0, manual_ms_enable}, 16'h0000);
        pulse(1'b0, 1);
        rc(REG_GIGABIT_LINK_STATUS, 16'h0000);
    endtask : t_fault

    task automatic t_idle();
        pulse(1'b1, 5);
        rc(REG_GIGABIT_LINK_STATUS, 16'h0005);
        rc(REG_GIGABIT_LINK_STATUS, 16'h0000);
        pulse(1'b1, 300);
        rc(REG_GIGABIT_LINK_STATUS, {8'h00, IDLE_COUNT_MAX});
        rc(REG_GIGABIT_LINK_STATUS, 16'h0000);
    endtask : t_idle

    task automatic t_reserved();
        host.wr(REG_GIGABIT_LINK_STATUS, 16'hFFFF);
        rc(REG_GIGABIT_LINK_STATUS, 16'h0000);
        host.wr(REG_GIGABIT_CAPABILITY, 16'hFFFF);
        rc(REG_GIGABIT_CAPABILITY, 16'h3000);
        host.wr(REG_INDIRECT_ACCESS_CONTROL, 16'hFFFF);
        rc(REG_INDIRECT_ACCESS_CONTROL, 16'hC01F);
    endtask : t_reserved

    task automatic t_window();
        host.ext_setup(FN_DATA_INC_RW, 16'h0020);
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'hA1A1);
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'hB2B2);
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'hC3C3);
        host.ext_setup(FN_DATA, 16'h0020);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hA1A1);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hA1A1);
        host.wr(REG_INDIRECT_ACCESS_CONTROL, host.ctl(FN_ADDRESS, DEVICE_ADDRESS_EXT));
        rc(REG_INDIRECT_ADDRESS_DATA, 16'h0020);
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'h0021);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'h0021);
        host.wr(REG_INDIRECT_ACCESS_CONTROL, host.ctl(FN_DATA_INC_RW, DEVICE_ADDRESS_EXT));
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hB2B2);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hC3C3);
        host.wr(REG_INDIRECT_ACCESS_CONTROL, host.ctl(FN_ADDRESS, DEVICE_ADDRESS_EXT));
        rc(REG_INDIRECT_ADDRESS_DATA, 16'h0023);
        host.ext_setup(FN_DATA_INC_WR, 16'h0020);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hA1A1);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hA1A1);
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'hD4D4);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hB2B2);
        host.ext_setup(FN_DATA, 16'h0010);
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'h5555);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'h0000);
        host.ext_setup(FN_DATA, 16'h0020);
        host.wr(REG_INDIRECT_ACCESS_CONTROL, host.ctl(FN_DATA, 5'h00));
        host.wr(REG_INDIRECT_ADDRESS_DATA, 16'h7777);
        rc(REG_INDIRECT_ADDRESS_DATA, 16'h0000);
        host.wr(REG_INDIRECT_ACCESS_CONTROL, host.ctl(FN_DATA, DEVICE_ADDRESS_EXT));
        rc(REG_INDIRECT_ADDRESS_DATA, 16'hD4D4);
    endtask : t_window

    // ========================================================================
    // Clock, reset, timeout and sequence
    // ========================================================================
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Roughly sixty frames of about 450 cycles each fit well inside this ceiling.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        resetn = 1'b0;
        ms_fault_event = 1'b0;
        st = 5'b00000;
        idle_error = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (5) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (2) @(posedge clock);
        t_reset_values();
        t_status();
        t_fault();
        t_idle();
        t_reserved();
        t_window();
        end_sim();
    end
endmodule : tb_top
